/* design/ccu_pkg.sv */
// Package: register map, field positions, reset values and enums of the comparator control unit
package ccu_pkg;

    // Register byte offsets (32-bit aligned words)
    localparam logic [7:0] CTRL_OFF     = 8'h00;
    localparam logic [7:0] CTRL_CLR_OFF = 8'h04;
    localparam logic [7:0] CTRL_SET_OFF = 8'h08;
    localparam logic [7:0] CTRL_INV_OFF = 8'h0C;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h14;

    // Field positions of comparator_control
    localparam int ENABLE_BIT     = 15;
    localparam int OUT_EN_BIT     = 14;
    localparam int INVERT_BIT     = 13;
    localparam int RESULT_BIT     = 8;
    localparam int EDGE_SEL_LO    = 6;
    localparam int POS_SEL_BIT    = 4;
    localparam int NEG_SEL_LO     = 0;

    // Writable bits of comparator_control; all others except the result bit read zero
    localparam logic [31:0] CTRL_WMASK  = 32'h0000_E0D3;
    // Value after reset: edge select 11, negative select 11
    localparam logic [31:0] CTRL_RESET  = 32'h0000_00C3;

    // Interrupt status bit positions
    localparam int IRQ_EDGE_BIT   = 0;
    localparam int IRQ_WIDTH      = 1;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Edge selections
    typedef enum logic [1:0]
    {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } ccu_edge_type;

endpackage

/* design/ccu_sync.sv */
// Two-flop synchroniser for the asynchronous comparator result
`timescale 1ns/1ps
module ccu_sync
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      dout
);

    typedef struct packed
    {
        logic stage1;
        logic stage2;
    } ccu_sync_state_type;

    ccu_sync_state_type state;
    ccu_sync_state_type next_state;

    // First stage feeds only the second stage
    always_comb
    begin
        next_state        = state;
        next_state.stage1 = din;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= '0;
        else
            state <= next_state;
    end

    assign dout = state.stage2;

endmodule

/* design/ccu_edge_detect.sv */
// Edge detector turning a synchronised level into one-cycle event pulses
`timescale 1ns/1ps
module ccu_edge_detect
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             level,
    input  wire logic             arm,
    input  ccu_pkg::ccu_edge_type edge_select,
    output logic                  event_pulse
);

    typedef struct packed
    {
        logic prev;
        logic armed;
        logic pulse;
    } ccu_edge_state_type;

    ccu_edge_state_type state;
    ccu_edge_state_type next_state;

    logic rise;
    logic fall;

    // A pulse needs a valid previous sample, so the first cycle after arming never fires
    always_comb
    begin
        next_state       = state;
        rise             = level & ~state.prev;
        fall             = ~level & state.prev;
        next_state.prev  = level;
        next_state.armed = arm;
        case (edge_select)
            ccu_pkg::EDGE_RISE: next_state.pulse = rise & state.armed & arm;
            ccu_pkg::EDGE_FALL: next_state.pulse = fall & state.armed & arm;
            ccu_pkg::EDGE_BOTH: next_state.pulse = (rise | fall) & state.armed & arm;
            default:            next_state.pulse = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= '0;
        else
            state <= next_state;
    end

    assign event_pulse = state.pulse;

endmodule

/* design/ccu_top.sv */
// Comparator control unit: AXI4-Lite register slave, input select, output path and edge interrupt
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////////////////////////

module ccu_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog core
    input  wire logic        comparator_result,
    output logic             comparator_enable,
    output logic             positive_input_select,
    output logic [1:0]       negative_input_select,
    // Output pin
    output logic             result_output_pin,
    output logic             result_output_pin_oe,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////////////////////

    typedef struct packed
    {
        logic [31:0]                    ctrl;
        logic [ccu_pkg::IRQ_WIDTH-1:0]  irq_stat;
        logic [ccu_pkg::IRQ_WIDTH-1:0]  irq_mask;
        logic                           aw_held;
        logic [7:0]                     aw_addr;
        logic                           w_held;
        logic [31:0]                    w_data;
        logic [3:0]                     w_strb;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [31:0]                    rdata;
        logic [1:0]                     rresp;
        logic                           pin_out;
        logic                           pin_oe;
    } ccu_top_state_type;

    ccu_top_state_type state;
    ccu_top_state_type next_state;

    logic        result_sync;
    logic        result_polar;
    logic        edge_event;
    logic        do_write;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [31:0] byte_mask;
    logic [31:0] bit_mask;
    logic [31:0] live_ctrl;

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Result is asynchronous to the bus clock, so it is resynchronised first
    ccu_sync u_sync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (comparator_result),
        .dout    (result_sync)
    );

    // Result, inverted when the invert bit is set, drives both pin and edge detector
    assign result_polar = result_sync ^ state.ctrl[ccu_pkg::INVERT_BIT];

    ccu_edge_detect u_edge
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .level       (result_polar),
        .arm         (state.ctrl[ccu_pkg::ENABLE_BIT]),
        .edge_select (ccu_pkg::ccu_edge_type'(state.ctrl[ccu_pkg::EDGE_SEL_LO +: 2])),
        .event_pulse (edge_event)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Handshake readiness: a channel is ready while nothing of its kind is held or pending
    assign s_axi_awready = ~state.aw_held & ~state.bvalid;
    assign s_axi_wready  = ~state.w_held & ~state.bvalid;
    assign s_axi_arready = ~state.rvalid;

    // Write fires once both address and data are present, held or arriving now
    always_comb
    begin
        do_write = (state.aw_held | (s_axi_awvalid & s_axi_awready))
                 & (state.w_held | (s_axi_wvalid & s_axi_wready));
        wr_addr  = state.aw_held ? state.aw_addr : s_axi_awaddr;
        wr_data  = state.w_held ? state.w_data : s_axi_wdata;
        byte_mask = '0;
        for (int i = 0; i < 4; i++)
        begin
            byte_mask[i*8 +: 8] = {8{state.w_held ? state.w_strb[i] : s_axi_wstrb[i]}};
        end
        bit_mask = wr_data & byte_mask & ccu_pkg::CTRL_WMASK;
    end

    // Readback merges stored bits with the live result; unused bits stay zero
    assign live_ctrl = (state.ctrl & ccu_pkg::CTRL_WMASK)
                     | (32'(result_sync) << ccu_pkg::RESULT_BIT);

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Next state: bus slave, control register and aliases, interrupt status
    always_comb
    begin
        next_state = state;

        // Capture address or data that arrive ahead of their partner
        if (s_axi_awvalid && s_axi_awready && !do_write)
        begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !do_write)
        begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end

        if (s_axi_bvalid && s_axi_bready)
            next_state.bvalid = 1'b0;

        if (do_write)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = ccu_pkg::RESP_OKAY;
            // Enable toggles never disturb the other bits: plain masked updates only
            case ({wr_addr[7:2], 2'h0})
                ccu_pkg::CTRL_OFF:
                    next_state.ctrl = (state.ctrl & ~(byte_mask & ccu_pkg::CTRL_WMASK)) | bit_mask;
                ccu_pkg::CTRL_CLR_OFF:
                    next_state.ctrl = state.ctrl & ~bit_mask;
                ccu_pkg::CTRL_SET_OFF:
                    next_state.ctrl = state.ctrl | bit_mask;
                ccu_pkg::CTRL_INV_OFF:
                    next_state.ctrl = state.ctrl ^ bit_mask;
                ccu_pkg::IRQ_STAT_OFF:
                    next_state.irq_stat = state.irq_stat & ~wr_data[ccu_pkg::IRQ_WIDTH-1:0];
                ccu_pkg::IRQ_MASK_OFF:
                    if (byte_mask[0])
                        next_state.irq_mask = wr_data[ccu_pkg::IRQ_WIDTH-1:0];
                default:
                    next_state.bresp = ccu_pkg::RESP_SLVERR;
            endcase
        end

        // Edge event set wins over a same-cycle clear
        if (edge_event)
            next_state.irq_stat[ccu_pkg::IRQ_EDGE_BIT] = 1'b1;

        if (s_axi_rvalid && s_axi_rready)
            next_state.rvalid = 1'b0;

        if (s_axi_arvalid && s_axi_arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = ccu_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
                ccu_pkg::CTRL_OFF:
                    next_state.rdata = live_ctrl;
                ccu_pkg::CTRL_CLR_OFF,
                ccu_pkg::CTRL_SET_OFF,
                ccu_pkg::CTRL_INV_OFF:
                    next_state.rdata = '0;
                ccu_pkg::IRQ_STAT_OFF:
                    next_state.rdata = 32'(state.irq_stat);
                ccu_pkg::IRQ_MASK_OFF:
                    next_state.rdata = 32'(state.irq_mask);
                default:
                begin
                    next_state.rdata = '0;
                    next_state.rresp = ccu_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Output pin: driven only when enabled, held low while the comparator is off
        next_state.pin_oe  = state.ctrl[ccu_pkg::OUT_EN_BIT];
        next_state.pin_out = result_polar & state.ctrl[ccu_pkg::ENABLE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // State register with synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state      <= '0;
            state.ctrl <= ccu_pkg::CTRL_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Outputs to the bus, the analog core, the pin and the interrupt line
    assign s_axi_bvalid          = state.bvalid;
    assign s_axi_bresp           = state.bresp;
    assign s_axi_rvalid          = state.rvalid;
    assign s_axi_rdata           = state.rdata;
    assign s_axi_rresp           = state.rresp;
    assign comparator_enable     = state.ctrl[ccu_pkg::ENABLE_BIT];
    assign positive_input_select = state.ctrl[ccu_pkg::POS_SEL_BIT];
    assign negative_input_select = state.ctrl[ccu_pkg::NEG_SEL_LO +: 2];
    assign result_output_pin     = state.pin_out;
    assign result_output_pin_oe  = state.pin_oe;
    assign irq                   = |(state.irq_stat & state.irq_mask);

endmodule

/* verification/ccu_top_properties.sv */
// Port-level assertions for the comparator control unit, bound to its top module
`timescale 1ns/1ps
module ccu_top_checker
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        comparator_enable,
    input wire logic        result_output_pin
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Handshake steps that the bus properties are built from
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    ////////////////////////////////////////////////////////////////////////////////
    property p_wr_resp; s_wr_take |=> s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while response pending");
    property p_rd_resp; s_rd_take |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read data late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped or changed");
    property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_block: assert property (p_r_block) else $error("read taken while data pending");
    property p_rd_unmapped; s_rd_take ##0 s_axi_araddr >= 8'h18 |=> s_axi_rresp == ccu_pkg::RESP_SLVERR; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
    property p_ctrl_rsvd; s_rd_take ##0 s_axi_araddr == 8'h00 |=> (s_axi_rdata & 32'hFFFF_1E2C) == 32'h0; endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("unused control bit reads one");
    property p_pin_idle; !comparator_enable ##1 !comparator_enable |-> !result_output_pin; endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin active while disabled");
endmodule
bind ccu_top ccu_top_checker u_chk (.*);

/* verification/ccu_analog_model.sv */
// Behavioural model of the analog comparator core and its input multiplexers
`timescale 1ns/1ps
module ccu_analog_model
(
    input wire logic        comparator_enable,
    input wire logic        positive_input_select,
    input wire logic [1:0]  negative_input_select,
    input wire logic [47:0] level,
    output logic            comparator_result
);
    logic [7:0] pos_level;
    logic [7:0] neg_level;
    // Level bytes: 0 pin A, 1 voltage ref, 2 to 4 pins B to D, 5 band ref
    assign pos_level = positive_input_select ? level[15:8] : level[7:0];
    assign neg_level = level[8 * (32'(negative_input_select) + 2) +: 8];
    // A core switched off draws no current, so its output rests low
    assign comparator_result = comparator_enable && (pos_level > neg_level);
endmodule

/* verification/comparator_control_unit_tb.sv */
// Self-checking bench for the comparator control unit
`timescale 1ns/1ps
module comparator_control_unit_tb;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, ctrl, d, got;
    logic [47:0] level = 0;
    logic        awready, wready, bvalid, arready, rvalid, res, en, pos, pin, oe, irq, ev;
    logic [1:0]  bresp, rresp, neg, resp;
    logic [15:0] seed = 16'hED5B;
    int          failures = 0, comparisons = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling so a hung handshake still reaches the verdict
    always #2 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            failures++;
            summarize;
        end
    end
    ccu_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comparator_result(res), .comparator_enable(en), .positive_input_select(pos),
        .negative_input_select(neg), .result_output_pin(pin), .result_output_pin_oe(oe), .irq(irq));
    ccu_analog_model u_core (.comparator_enable(en), .positive_input_select(pos),
        .negative_input_select(neg), .level(level), .comparator_result(res));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected comparator output for a control word and the input levels
    function automatic logic result_of(input logic [31:0] c, input logic [47:0] l);
        logic [7:0] p;
        logic [7:0] n;
        p = c[4] ? l[15:8] : l[7:0];
        n = l[8 * (32'(c[1:0]) + 2) +: 8];
        return c[15] && (p > n);
    endfunction
    // Whether a detector edge of the given direction raises an event
    function automatic logic event_of(input logic [1:0] e, input logic rise);
        return e == 2'h3 || (rise ? e == 2'h1 : e == 2'h2);
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            failures++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask
    // Both halves offered together, each released once taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        // A cycle of back-pressure so the response hold checks see a stall
        bready <= 1;
        @(posedge aclk);
        resp = bresp;
        bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        // Data must stand through a stalled cycle before it is taken
        rready <= 1;
        @(posedge aclk);
        got = rdata;
        resp = rresp;
        rready <= 0;
    endtask
    task summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rd(8'h00);
        check(got, 32'h0000_00C3);
        $display("reset test done");
        // Random control words with random input levels
        repeat (16)
        begin
            seed = lfsr(seed);
            d[15:0] = seed;
            seed = lfsr(seed);
            d[31:16] = seed;
            level <= {seed, d};
            wr(8'h00, d);
            ctrl = d & ccu_pkg::CTRL_WMASK;
            repeat (4) @(posedge aclk);
            rd(8'h00);
            check(got, ctrl | {23'h0, result_of(ctrl, level), 8'h0});
            check({26'h0, en, pos, neg, oe, pin}, {26'h0, ctrl[15], ctrl[4], ctrl[1:0], ctrl[14],
                ctrl[15] & (result_of(ctrl, level) ^ ctrl[13])});
        end
        // Clear, set and invert aliases with random masks
        for (int k = 1; k < 4; k++)
        begin
            seed = lfsr(seed);
            wr(8'(4 * k), {16'h0, seed});
            check({30'h0, resp}, {30'h0, ccu_pkg::RESP_OKAY});
            ctrl = (k == 1 ? ctrl & ~{16'h0, seed} : k == 2 ? ctrl | seed : ctrl ^ seed) & ccu_pkg::CTRL_WMASK;
            rd(8'h00);
            check(got & ~32'h100, ctrl);
        end
        // Unmapped places are refused and leave the control word alone
        wr(8'h18, 32'hFFFF_FFFF);
        check({30'h0, resp}, {30'h0, ccu_pkg::RESP_SLVERR});
        rd(8'h3C);
        check({30'h0, resp}, {30'h0, ccu_pkg::RESP_SLVERR});
        rd(8'h00);
        check(got & ~32'h100, ctrl);
        $display("register test done");
        // Every edge selection, with and without inversion, both directions
        wr(8'h14, 32'h1);
        for (int k = 0; k < 8; k++)
        begin
            level <= 48'h8000_0000_0000;
            wr(8'h00, 32'h0000_C013 | (32'(k[0]) << 13) | (32'(k[2:1]) << 6));
            // Settle first: the control change itself may look like an edge
            repeat (10) @(posedge aclk);
            wr(8'h10, 32'h1);
            level <= 48'h8000_0000_FF00;
            repeat (10) @(posedge aclk);
            check({31'h0, pin}, {31'h0, ~k[0]});
            ev = event_of(k[2:1], !k[0]);
            rd(8'h10);
            check(got, {31'h0, ev});
            check({31'h0, irq}, {31'h0, ev});
            wr(8'h10, 32'h1);
            level <= 48'h8000_0000_0000;
            repeat (10) @(posedge aclk);
            rd(8'h10);
            check(got, {31'h0, event_of(k[2:1], k[0])});
        end
        // Masked event keeps the interrupt line low
        wr(8'h14, 32'h0);
        check({31'h0, irq}, 32'h0);
        rd(8'h14);
        check(got, 32'h0);
        wr(8'h10, 32'h1);
        $display("event test done");
        // Disabled unit raises no event and holds the pin low
        wr(8'h00, 32'h0000_60D3);
        wr(8'h10, 32'h1);
        level <= 48'h8000_0000_FF00;
        repeat (10) @(posedge aclk);
        check({30'h0, en, pin}, 32'h0);
        // The core rests low when off, so only an inversion flip moves the detector input
        wr(8'h0C, 32'h0000_2000);
        repeat (10) @(posedge aclk);
        rd(8'h10);
        check(got, 32'h0);
        rd(8'h00);
        check(got, 32'h0000_40D3);
        $display("disable test done");
        summarize;
    end
endmodule
